// ===== src/uart_zero_serial_port.sv
// Full-duplex serial port with register access and pin routing.
`timescale 1ns/1ps
`include "uart_zero_defs.svh"
module uart_zero_serial_port
  import uart_zero_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire sfr_req_t   sfr_req,
  output logic      [7:0] sfr_rdata,
  input  wire logic [2:0] rxd_pin,
  output logic      [2:0] txd_pin,
  output logic            irq
);
  logic [7:0] baud_low_r;
  ctrl_one_t  ctrl_one_r;
  logic [7:0] ctrl_two_r;
  logic [7:0] pin_route_r;
  logic [7:0] rx_buf_r;
  logic       rx_ninth_r;
  logic       tx_ninth_r;
  logic [4:0] flag_r;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [7:0] sfr_rdata_r;
  logic [7:0] rd_mux;

  logic wr_baud_low;
  logic wr_ctrl_one;
  logic wr_ctrl_two;
  logic wr_flags;
  logic wr_data;
  logic wr_route;
  logic port_on;
  logic rx_run;
  logic tick;
  logic [9:0] divisor;
  logic [1:0] pin_sel;

  assign wr_baud_low = sfr_req.wr && sfr_req.addr == `BAUD_LOW_ADDR;
  assign wr_ctrl_one = sfr_req.wr && sfr_req.addr == `CTRL_ONE_ADDR;
  assign wr_ctrl_two = sfr_req.wr && sfr_req.addr == `CTRL_TWO_ADDR;
  assign wr_flags    = sfr_req.wr && sfr_req.addr == `FLAGS_ADDR;
  assign wr_data     = sfr_req.wr && sfr_req.addr == `DATA_ADDR;
  assign wr_route    = sfr_req.wr && sfr_req.addr == `PIN_ROUTE_ADDR;
  assign port_on     = ctrl_one_r.port_on;
  assign rx_run      = port_on && ctrl_one_r.rx_on;
  assign divisor = {ctrl_two_r[`DIV_HIGH_MSB:0], baud_low_r};
  assign pin_sel = pin_route_r[`PIN_SEL_MSB:`PIN_SEL_LSB];

  baud_tick_gen u_baud (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (port_on),
    .restart (wr_baud_low || wr_ctrl_two),
    .divisor (divisor),
    .tick    (tick)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      baud_low_r  <= `BAUD_LOW_RST;
      ctrl_one_r  <= `CTRL_ONE_RST;
      ctrl_two_r  <= `CTRL_TWO_RST;
      pin_route_r <= `PIN_ROUTE_RST;
    end else begin
      if (wr_baud_low) baud_low_r <= sfr_req.wdata;
      if (wr_ctrl_one) ctrl_one_r <= {1'b0, sfr_req.wdata[6:0]};
      if (wr_ctrl_two) ctrl_two_r <= {4'h0, sfr_req.wdata[3:0]};
      if (wr_route) pin_route_r <= {1'b0, sfr_req.wdata[6:0]};
    end
  end

  // Transmitter.
  tx_state_t  tx_state_r;
  logic [11:0] tx_shift_r;
  logic [3:0]  tx_bits_r;
  logic [3:0]  tx_slot_r;
  logic        tx_load;
  logic        tx_bit_end;
  logic        tx_done;
  logic        tx_par;
  logic        tx_ninth;
  logic [11:0] tx_frame;
  logic [3:0]  tx_total;
  logic        tx_line;

  assign tx_load = wr_data && port_on && tx_state_r == TX_IDLE;
  assign tx_par  = ^sfr_req.wdata ^ ctrl_one_r.par_odd;
  // Ninth bit is parity or stored bit.
  assign tx_ninth = ctrl_one_r.par_en ? tx_par : tx_ninth_r;
  assign tx_frame = ctrl_one_r.nine_bit
                  ? {2'b11, tx_ninth, sfr_req.wdata, 1'b0}
                  : ctrl_one_r.par_en
                  ? {3'b111, ^sfr_req.wdata[6:0] ^ ctrl_one_r.par_odd,
                     sfr_req.wdata[6:0], 1'b0}
                  : {3'b111, sfr_req.wdata, 1'b0};
  assign tx_total = 4'd10 + {3'b000, ctrl_one_r.nine_bit}
                  + {3'b000, ctrl_one_r.two_stop};
  assign tx_bit_end = tx_state_r == TX_SHIFT && tick
                   && tx_slot_r == `SLOTS_PER_BIT;
  assign tx_done = tx_bit_end && tx_bits_r == 4'd1;
  assign tx_line = tx_state_r == TX_SHIFT ? tx_shift_r[0] : 1'b1;

  always_ff @(posedge clk) begin
    if (sys_rst || !port_on) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 12'hfff;
      tx_bits_r  <= 4'h0;
      tx_slot_r  <= 4'h0;
    end else if (tx_load) begin
      tx_state_r <= TX_SHIFT;
      tx_shift_r <= tx_frame;
      tx_bits_r  <= tx_total;
      tx_slot_r  <= 4'h0;
    end else if (tx_state_r == TX_SHIFT && tick) begin
      tx_slot_r <= tx_slot_r + 4'h1;
      if (tx_bit_end) begin
        tx_shift_r <= {1'b1, tx_shift_r[11:1]};
        tx_bits_r  <= tx_bits_r - 4'h1;
        if (tx_done) tx_state_r <= TX_IDLE;
      end
    end
  end

  // Receiver. Every pin passes two flops before the pair select reads
  // it; a select change mid-character corrupts that character.
  rx_state_t  rx_state_r;
  logic [2:0] rx_meta_r;
  logic [2:0] rx_sync_r;
  logic [2:0] rx_hist_r;
  logic [3:0] rx_slot_r;
  logic [3:0] rx_bit_r;
  logic [1:0] rx_vote_r;
  logic [8:0] rx_shift_r;
  logic       rx_pin;
  logic       rx_in;
  logic       rx_edge;
  logic       rx_decide;
  logic       rx_maj;
  logic [3:0] rx_last;
  logic       rx_stop;
  logic [8:0] rx_char;
  logic       rx_keep;
  logic       rx_store;

  assign rx_pin = pin_sel[1] ? rx_sync_r[2] : pin_sel[0] ? rx_sync_r[1]
                : rx_sync_r[0];
  assign rx_in = rx_pin;
  assign rx_edge = rx_state_r == RX_IDLE && tick && rx_hist_r == 3'b111
                && !rx_in;
  assign rx_decide = rx_state_r == RX_BITS && tick
                  && rx_slot_r == `VOTE_LAST_SLOT;
  assign rx_maj = (rx_vote_r[0] & rx_vote_r[1]) | (rx_vote_r[0] & rx_in)
                | (rx_vote_r[1] & rx_in);
  assign rx_last = ctrl_one_r.nine_bit ? 4'd10 : 4'd9;
  assign rx_stop = rx_decide && rx_bit_r == rx_last;
  assign rx_char = ctrl_one_r.nine_bit ? rx_shift_r
                 : {1'b0, rx_shift_r[8:1]};
  assign rx_keep = !(ctrl_one_r.addr_filter && ctrl_one_r.nine_bit
                     && !rx_char[8]);
  assign rx_store = rx_stop && rx_keep
                 && !flag_r[`FLAG_RX_FULL_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_meta_r <= 3'b111;
      rx_sync_r <= 3'b111;
      rx_hist_r <= 3'b000;
    end else begin
      rx_meta_r <= rxd_pin;
      rx_sync_r <= rx_meta_r;
      if (tick) rx_hist_r <= {rx_hist_r[1:0], rx_in};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !rx_run) begin
      rx_state_r <= RX_IDLE;
      rx_slot_r  <= 4'h0;
      rx_bit_r   <= 4'h0;
      rx_vote_r  <= 2'b00;
      rx_shift_r <= 9'h000;
    end else if (rx_edge) begin
      rx_state_r <= RX_BITS;
      rx_slot_r  <= 4'h1;
      rx_bit_r   <= 4'h0;
    end else if (rx_state_r == RX_BITS && tick) begin
      rx_slot_r <= rx_slot_r + 4'h1;
      if (rx_slot_r >= `VOTE_FIRST_SLOT && !rx_decide) begin
        rx_vote_r <= {rx_vote_r[0], rx_in};
      end
      if (rx_decide) begin
        rx_bit_r <= rx_bit_r + 4'h1;
        if ((rx_bit_r == 4'h0 && rx_maj) || rx_stop) begin
          rx_state_r <= RX_IDLE;
        end
        if (rx_bit_r != 4'h0 && !rx_stop) begin
          rx_shift_r <= {rx_maj, rx_shift_r[8:1]};
        end
      end
    end
  end

  // Data, ninth bits and flags.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_buf_r   <= `DATA_RST;
      rx_ninth_r <= 1'b0;
      tx_ninth_r <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_buf_r <= rx_char[7:0];
        rx_ninth_r <= rx_char[8] & ctrl_one_r.nine_bit;
      end
      if (wr_flags && !ctrl_one_r.par_en) begin
        tx_ninth_r <= sfr_req.wdata[`FLAG_TX_NINTH_BIT];
      end
    end
  end

  assign flag_set[`FLAG_TX_DONE_BIT]  = tx_done;
  assign flag_set[`FLAG_RX_FULL_BIT]  = rx_store;
  assign flag_set[`FLAG_OVERFLOW_BIT] = rx_stop && rx_keep
                                     && flag_r[`FLAG_RX_FULL_BIT];
  assign flag_set[`FLAG_FRAME_BIT]    = rx_stop && rx_keep && !rx_maj;
  assign flag_set[`FLAG_PARITY_BIT]   = rx_stop && rx_keep
    && ctrl_one_r.par_en
    && ((ctrl_one_r.nine_bit ? ^rx_char : ^rx_char[7:0])
        != ctrl_one_r.par_odd);

  // A set in the same cycle as a clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      assign flag_clr[gi] = wr_flags && !sfr_req.wdata[gi];
      always_ff @(posedge clk) begin
        if (sys_rst) flag_r[gi] <= 1'b0;
        else if (flag_set[gi]) flag_r[gi] <= 1'b1;
        else if (flag_clr[gi]) flag_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_comb begin
    if (sfr_req.addr == `BAUD_LOW_ADDR) rd_mux = baud_low_r;
    else if (sfr_req.addr == `CTRL_ONE_ADDR) rd_mux = ctrl_one_r;
    else if (sfr_req.addr == `CTRL_TWO_ADDR) rd_mux = ctrl_two_r;
    else if (sfr_req.addr == `FLAGS_ADDR) begin
      rd_mux = {1'b0, rx_ninth_r, tx_ninth_r, flag_r};
    end
    else if (sfr_req.addr == `DATA_ADDR) rd_mux = rx_buf_r;
    else if (sfr_req.addr == `PIN_ROUTE_ADDR) rd_mux = pin_route_r;
    else rd_mux = 8'h00;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) sfr_rdata_r <= 8'h00;
    else if (sfr_req.rd) sfr_rdata_r <= rd_mux;
  end
  assign sfr_rdata = sfr_rdata_r;

  assign txd_pin[0] = pin_sel == 2'b00 ? tx_line : 1'b1;
  assign txd_pin[1] = pin_sel == 2'b01 ? tx_line : 1'b1;
  assign txd_pin[2] = pin_sel[1] ? tx_line : 1'b1;

  assign irq = (flag_r[`FLAG_TX_DONE_BIT] && ctrl_two_r[`TXE_IRQ_MASK_BIT])
            || (flag_r[`FLAG_RX_FULL_BIT] && ctrl_two_r[`RXF_IRQ_MASK_BIT]);

  chk_flag_set_wins : assert property (@(posedge clk) disable iff (sys_rst)
    flag_set[`FLAG_RX_FULL_BIT] |=> flag_r[`FLAG_RX_FULL_BIT])
    else $error("receive flag lost");
  chk_one_write_sticky : assert property (@(posedge clk) disable iff (sys_rst)
    flag_r[`FLAG_TX_DONE_BIT] && wr_flags
    && sfr_req.wdata[`FLAG_TX_DONE_BIT] |=> flag_r[`FLAG_TX_DONE_BIT])
    else $error("write one cleared flag");
  chk_overflow_keeps : assert property (@(posedge clk) disable iff (sys_rst)
    flag_set[`FLAG_OVERFLOW_BIT] |=> $stable(rx_buf_r))
    else $error("overflow overwrote buffer");
  chk_filter_drops : assert property (@(posedge clk) disable iff (sys_rst)
    rx_stop && ctrl_one_r.addr_filter && ctrl_one_r.nine_bit && !rx_char[8]
    |-> !flag_set[`FLAG_RX_FULL_BIT]) else $error("filter missed");
  chk_irq_gating : assert property (@(posedge clk) disable iff (sys_rst)
    irq |-> ctrl_two_r[3:2] != 2'b00 && flag_r[4:3] != 2'b00)
    else $error("ungated interrupt");
  chk_errors_no_irq : assert property (@(posedge clk) disable iff (sys_rst)
    flag_r[4:3] == 2'b00 |-> !irq) else $error("error raised irq");
  chk_tx_start_low : assert property (@(posedge clk) disable iff (sys_rst)
    tx_load |=> (tx_line == 1'b0) [*2]) else $error("no start bit");
  chk_port_off_idle : assert property (@(posedge clk) disable iff (sys_rst)
    !port_on |=> txd_pin == 3'b111 && rx_state_r == RX_IDLE)
    else $error("activity while off");
  chk_done_after_stop : assert property (@(posedge clk) disable iff (sys_rst)
    tx_done |-> tx_line == 1'b1) else $error("done before stop");
  chk_reset_data : assert property (@(posedge clk)
    sys_rst |=> rx_buf_r == 8'hff && ctrl_two_r == 8'h0c)
    else $error("bad reset value");

  cov_tx_frame : cover property (@(posedge clk) tx_done);
  cov_rx_store : cover property (@(posedge clk) rx_store);
  cov_overflow : cover property (@(posedge clk) flag_set[2]);
  cov_false_start : cover property (@(posedge clk)
    rx_decide && rx_bit_r == 4'h0 && rx_maj);
endmodule : uart_zero_serial_port

// ===== src/uart_zero_defs.svh
// Register offsets, field positions and reset values of the serial port.
`ifndef UART_ZERO_DEFS_SVH
`define UART_ZERO_DEFS_SVH
`define BAUD_LOW_ADDR      8'hbd
`define CTRL_ONE_ADDR      8'hbe
`define CTRL_TWO_ADDR      8'hbf
`define FLAGS_ADDR         8'hc0
`define DATA_ADDR          8'hc1
`define PIN_ROUTE_ADDR     8'hf2
`define BAUD_LOW_RST       8'h00
`define CTRL_ONE_RST       8'h00
`define CTRL_TWO_RST       8'h0c
`define DATA_RST           8'hff
`define PIN_ROUTE_RST      8'h40
`define TXE_IRQ_MASK_BIT   3
`define RXF_IRQ_MASK_BIT   2
`define DIV_HIGH_MSB       1
`define FLAG_RX_NINTH_BIT  6
`define FLAG_TX_NINTH_BIT  5
`define FLAG_TX_DONE_BIT   4
`define FLAG_RX_FULL_BIT   3
`define FLAG_OVERFLOW_BIT  2
`define FLAG_FRAME_BIT     1
`define FLAG_PARITY_BIT    0
`define PIN_SEL_LSB        3
`define PIN_SEL_MSB        4
`define SLOTS_PER_BIT      4'd15
`define VOTE_FIRST_SLOT    4'd7
`define VOTE_LAST_SLOT     4'd9
`endif

// ===== src/uart_zero_pkg.sv
// Types shared by the serial port design files.
package uart_zero_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;
  typedef struct packed {
    logic spare;
    logic port_on;
    logic rx_on;
    logic addr_filter;
    logic two_stop;
    logic nine_bit;
    logic par_en;
    logic par_odd;
  } ctrl_one_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic {RX_IDLE, RX_BITS} rx_state_t;
endpackage : uart_zero_pkg

// ===== src/baud_tick_gen.sv
// Sixteen-times baud tick generator with a ten-bit divisor.
`timescale 1ns/1ps
module baud_tick_gen
  import uart_zero_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [9:0] divisor,
  output logic            tick
);
  logic [9:0] cnt_r;
  logic       wrap;

  assign wrap = (divisor != 10'h000) && (cnt_r >= divisor - 10'h001);
  assign tick = run && wrap && !restart;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 10'h000;
    end else if (restart || !run || wrap) begin
      cnt_r <= 10'h000;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  chk_zero_div_silent : assert property (@(posedge clk) disable iff (sys_rst)
    divisor == 10'h000 |-> !tick) else $error("tick with zero divisor");
  chk_restart_clears : assert property (@(posedge clk) disable iff (sys_rst)
    restart |=> cnt_r == 10'h000) else $error("restart kept count");
  chk_tick_spacing : assert property (@(posedge clk) disable iff (sys_rst)
    tick && divisor == 10'h003 && $stable(divisor) |=> !tick ##1 !tick)
    else $error("ticks closer than divisor");
endmodule : baud_tick_gen

// ===== test/serial_partner.sv
// Behavioural far-side transceiver on the selected pin pair.
`timescale 1ns/1ps
module serial_partner (
  input  wire logic       clk,
  input  wire logic [1:0] pair,
  input  wire logic [2:0] txd_pin,
  output logic      [2:0] rxd_pin
);
  logic       line_r   = 1'b1;
  int         bit_clks = 16;
  wire  [1:0] idx      = pair[1] ? 2'd2 : pair;

  // Unselected pins idle high, as the pull-ups would hold them.
  always_comb begin
    rxd_pin      = 3'b111;
    rxd_pin[idx] = line_r;
  end

  // Start bit sits in bit 0, each bit lasts one full bit time.
  task automatic send_frame(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      line_r = bits[i];
      repeat (bit_clks - 1) @(negedge clk);
    end
    @(negedge clk);
    line_r = 1'b1;
  endtask : send_frame

  // A short low pulse that must not pass the start vote.
  task automatic pulse(input int n);
    @(negedge clk);
    line_r = 1'b0;
    repeat (n) @(negedge clk);
    line_r = 1'b1;
  endtask : pulse

  // Bits are sampled mid-bit; a missing start edge leaves all ones.
  task automatic recv_frame(output logic [11:0] bits, input int n);
    int w;
    bits = '1;
    w    = 0;
    while (txd_pin[idx] !== 1'b0 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    repeat (bit_clks / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_pin[idx];
      repeat (bit_clks) @(negedge clk);
    end
  endtask : recv_frame
endmodule : serial_partner

// ===== test/tb_top.sv
// Self-checking bench for the serial port and its pin routing.
`timescale 1ns/1ps
module tb_top
  import uart_zero_pkg::*;
;
  logic       clk = 1'b0;
  logic       sys_rst;
  sfr_req_t   sfr_req;
  logic [7:0] sfr_rdata;
  logic [2:0] rxd_pin;
  logic [2:0] txd_pin;
  logic       irq;
  logic [1:0] pair;
  logic       tx_ninth_exp = 1'b0;
  int         num_errors = 0;
  int         n_checks = 0;

  always #10 clk = ~clk;

  uart_zero_serial_port i_uart_zero_serial_port (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sfr_req   (sfr_req),
    .sfr_rdata (sfr_rdata),
    .rxd_pin   (rxd_pin),
    .txd_pin   (txd_pin),
    .irq       (irq)
  );

  serial_partner i_serial_partner (
    .clk     (clk),
    .pair    (pair),
    .txd_pin (txd_pin),
    .rxd_pin (rxd_pin)
  );

  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : check

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req.addr  = a;
    sfr_req.wdata = d;
    sfr_req.wr    = 1'b1;
    @(negedge clk);
    sfr_req.wr    = 1'b0;
  endtask : sfr_wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_req.addr = a;
    sfr_req.rd   = 1'b1;
    @(negedge clk);
    sfr_req.rd   = 1'b0;
    check({4'h0, sfr_rdata}, {4'h0, exp});
  endtask : rd_chk

  task automatic flags_chk(input logic [7:0] f, input logic i);
    rd_chk(8'hc0, f);
    check({11'h0, irq}, {11'h0, i});
  endtask : flags_chk

  // Parity replaces data bit 7 in 8-bit mode, the ninth bit otherwise.
  function automatic logic [11:0] frame(input logic [8:0] d,
                                        input logic [7:0] c1);
    logic [8:0] x;
    x = d;
    if (c1[1] && !c1[2])
      x[7] = ^d[6:0] ^ c1[0];
    if (c1[1] && c1[2])
      x[8] = ^d[7:0] ^ c1[0];
    frame = c1[2] ? {2'b11, x, 1'b0} : {3'b111, x[7:0], 1'b0};
  endfunction : frame

  task automatic rx_send(input logic [8:0] d, input logic [7:0] c1,
                         input logic [11:0] flip);
    i_serial_partner.send_frame(frame(d, c1) ^ flip, 10 + c1[2] + c1[3]);
    repeat (4) @(negedge clk);
  endtask : rx_send

  task automatic tx_chk(input logic [8:0] d, input logic [7:0] c1);
    logic [11:0] got;
    logic [2:0]  sel;
    sel = 3'b001 << (pair[1] ? 2'd2 : pair);
    sfr_wr(8'hc0, {2'b00, d[8], 5'h1f});
    if (!c1[1])
      tx_ninth_exp = d[8];
    fork
      sfr_wr(8'hc1, d[7:0]);
      i_serial_partner.recv_frame(got, 10 + c1[2] + c1[3]);
      begin
        repeat (10) @(negedge clk);
        check({9'h0, txd_pin}, {9'h0, ~sel});
      end
    join
    check(got, frame(d, c1));
    repeat (4) @(negedge clk);
    flags_chk({2'b00, tx_ninth_exp, 5'h10}, 1'b1);
    // Writing ones over a set flag must leave it standing.
    sfr_wr(8'hc0, {2'b00, d[8], 5'h1f});
    flags_chk({2'b00, tx_ninth_exp, 5'h10}, 1'b1);
  endtask : tx_chk

  task automatic reset_chk();
    logic [7:0] a [7] = '{8'hbd, 8'hbe, 8'hbf, 8'hc0, 8'hc1, 8'hf2, 8'hc2};
    logic [7:0] e [7] = '{8'h00, 8'h00, 8'h0c, 8'h00, 8'hff, 8'h40, 8'h00};
    for (int i = 0; i < 7; i++)
      rd_chk(a[i], e[i]);
    check({8'h0, txd_pin, irq}, 12'h00e);
  endtask : reset_chk

  task automatic port_off_chk();
    sfr_wr(8'hbf, 8'h0f);
    rd_chk(8'hbf, 8'h0f);
    sfr_wr(8'hbf, 8'h0c);
    sfr_wr(8'hbd, 8'h01);
    sfr_wr(8'hc1, 8'h00);
    repeat (20) @(negedge clk);
    check({9'h0, txd_pin}, 12'h007);
    flags_chk(8'h00, 1'b0);
  endtask : port_off_chk

  task automatic tx_modes();
    logic [7:0] c1 [4] = '{8'h60, 8'h6b, 8'h66, 8'h6c};
    logic [8:0] d  [4] = '{9'h0a5, 9'h03c, 9'h0c3, 9'h1e1};
    for (int i = 0; i < 4; i++) begin
      sfr_wr(8'hbe, c1[i]);
      rd_chk(8'hbe, c1[i]);
      sfr_wr(8'hbd, 8'(i + 1));
      sfr_wr(8'hf2, 8'h40 | 8'(i << 3));
      pair = 2'(i);
      i_serial_partner.bit_clks = 16 * (i + 1);
      tx_chk(d[i], c1[i]);
      sfr_wr(8'hc0, 8'h0f);
      if (!c1[i][1])
        tx_ninth_exp = 1'b0;
      flags_chk({2'b00, tx_ninth_exp, 5'h00}, 1'b0);
    end
  endtask : tx_modes

  task automatic rx_buffer();
    sfr_wr(8'hbe, 8'h60);
    sfr_wr(8'hbd, 8'h01);
    sfr_wr(8'hf2, 8'h40);
    pair = 2'd0;
    i_serial_partner.bit_clks = 16;
    rx_send(9'h05a, 8'h60, 12'h000);
    flags_chk(8'h08, 1'b1);
    rx_send(9'h033, 8'h60, 12'h000);
    flags_chk(8'h0c, 1'b1);
    rd_chk(8'hc1, 8'h5a);
    sfr_wr(8'hc0, 8'h1f);
    flags_chk(8'h0c, 1'b1);
    sfr_wr(8'hc0, 8'h00);
    flags_chk(8'h00, 1'b0);
    i_serial_partner.pulse(4);
    repeat (40) @(negedge clk);
    flags_chk(8'h00, 1'b0);
  endtask : rx_buffer

  task automatic rx_errors();
    sfr_wr(8'hbe, 8'h62);
    rx_send(9'h041, 8'h62, 12'h100);
    flags_chk(8'h09, 1'b1);
    sfr_wr(8'hc0, 8'h00);
    sfr_wr(8'hbe, 8'h60);
    sfr_wr(8'hbf, 8'h08);
    rd_chk(8'hbf, 8'h08);
    rx_send(9'h07e, 8'h60, 12'h200);
    flags_chk(8'h0a, 1'b0);
    sfr_wr(8'hc0, 8'h00);
    sfr_wr(8'hbf, 8'h0c);
  endtask : rx_errors

  task automatic rx_filter();
    sfr_wr(8'hbe, 8'h74);
    rx_send(9'h012, 8'h74, 12'h000);
    flags_chk(8'h00, 1'b0);
    rx_send(9'h134, 8'h74, 12'h000);
    flags_chk(8'h48, 1'b1);
    rd_chk(8'hc1, 8'h34);
    sfr_wr(8'hc0, 8'h00);
    flags_chk(8'h40, 1'b0);
    // A closed receiver must ignore a whole valid character.
    sfr_wr(8'hbe, 8'h40);
    rx_send(9'h055, 8'h40, 12'h000);
    flags_chk(8'h40, 1'b0);
  endtask : rx_filter

  // The whole run needs a few thousand cycles; this is ample margin.
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    sfr_req = '0;
    pair    = 2'd0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    reset_chk();
    port_off_chk();
    tx_modes();
    rx_buffer();
    rx_errors();
    rx_filter();
    finish_test();
  end
endmodule : tb_top
